//--- design/flash_read_seq.sv
`timescale 1ns/1ps

// Stretches one flash read over 1 to 4 bus cycles
module flash_read_seq (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Read request and setting
  input  wire logic       start,
  input  wire logic [1:0] wait_code,
  // Progress
  output logic            busy_q,
  output logic            ready_q
);

  sysctl_pkg::rd_state_t state_q;          // Current state
  sysctl_pkg::rd_state_t state_d;          // Next state
  logic [1:0]            cnt_q;            // Remaining wait cycles
  logic                  last;             // Final cycle of the read

  assign last = (state_q == sysctl_pkg::RD_BUSY) && (cnt_q == 2'h0);

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      sysctl_pkg::RD_IDLE: begin
        if (start) begin
          state_d = sysctl_pkg::RD_BUSY;
        end
      end
      sysctl_pkg::RD_BUSY: begin
        if (last) begin
          state_d = sysctl_pkg::RD_IDLE;
        end
      end
      default: begin
        state_d = sysctl_pkg::RD_IDLE;
      end
    endcase
  end

  // Setting is latched at start so a change never cuts a read short
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= sysctl_pkg::RD_IDLE;
      cnt_q   <= 2'h0;
      busy_q  <= 1'b0;
      ready_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= (state_q == sysctl_pkg::RD_IDLE) ? wait_code : cnt_q - 2'h1;
      busy_q  <= (state_d == sysctl_pkg::RD_BUSY);
      ready_q <= last;
    end
  end

endmodule

//--- design/sys_protect_cache_flash_wait.sv
`timescale 1ns/1ps
`include "sysctl_consts.svh"


module sys_protect_cache_flash_wait (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic      [15:0] rdata,
  // Instruction cache control
  output logic             cache_enable,
  output logic             cache_flush,
  // Flash read timing
  input  wire logic        flash_req,
  output logic             flash_busy,
  output logic             flash_ready,
  output logic      [1:0]  flash_wait_code,
  // Protection state for other system registers
  output logic             sys_unlocked
);

  // ----------------------------------------------------------
  // Request bundle
  // ----------------------------------------------------------

  sysctl_pkg::bus_req_t req;               // Port signals together

  assign req.addr  = addr;
  assign req.wdata = wdata;
  assign req.wr    = wr_stb;
  assign req.rd    = rd_stb;

  // ----------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------

  logic hit_lock;                          // Key register selected
  logic hit_cache;                         // Cache control selected
  logic hit_wait;                          // Read-wait selected
  logic hit_stat;                          // Status selected

  // One compare used for every register
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign hit_lock  = hit(req.addr, `OFS_LOCK);
  assign hit_cache = hit(req.addr, `OFS_CACHE);
  assign hit_wait  = hit(req.addr, `OFS_WAIT);
  assign hit_stat  = hit(req.addr, `OFS_STAT);

  // ----------------------------------------------------------
  // Write strobes per register
  // ----------------------------------------------------------

  logic wr_lock;                           // Key write
  logic wr_cache;                          // Cache control write
  logic wr_wait_any;                       // Any read-wait write
  logic wr_wait;                           // Read-wait write accepted
  logic wr_wait_drop;                      // Read-wait write discarded
  logic wr_stat;                           // Status write
  logic lock_open;                         // Protection lifted

  assign wr_lock      = req.wr && hit_lock;
  assign wr_cache     = req.wr && hit_cache;
  assign wr_wait_any  = req.wr && hit_wait;
  // Protected field takes the write only while unlocked
  assign wr_wait      = wr_wait_any && lock_open;
  // Otherwise the write completes but only sets the drop flag
  assign wr_wait_drop = wr_wait_any && !lock_open;
  assign wr_stat      = req.wr && hit_stat;

  // ----------------------------------------------------------
  // Write-lock key
  // ----------------------------------------------------------

  logic [15:0] key_q;                      // Stored key word

  // Key stays open until a non-key word is written
  write_lock_key u_lock (
    .clk      (clk),
    .rst      (rst),
    .key_wr   (wr_lock),
    .key_data (req.wdata),
    .key_q    (key_q),
    .open_q   (lock_open)
  );

  // ----------------------------------------------------------
  // Cache control
  // ----------------------------------------------------------

  logic cache_en_q;                        // Enable bit
  logic cache_en_d;                        // Next enable bit
  logic cache_flush_d;                     // Invalidate request
  logic cache_flush_q;                     // Invalidate pulse

  assign cache_en_d    = wr_cache ? req.wdata[`CACHE_EN_POS] : cache_en_q;
  // Writing zero drops every held word, even if already off
  assign cache_flush_d = wr_cache && !req.wdata[`CACHE_EN_POS];

  // Enable bit off after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      cache_en_q    <= `CACHE_EN_RST;
      cache_flush_q <= 1'b0;
    end else begin
      cache_en_q    <= cache_en_d;
      cache_flush_q <= cache_flush_d;
    end
  end

  // ----------------------------------------------------------
  // Flash read-wait
  // ----------------------------------------------------------

  logic [1:0] wait_q;                      // Wait code
  logic [1:0] wait_d;                      // Next wait code
  logic       wait_rsv_q;                  // Spare protected bit
  logic       wait_rsv_d;                  // Next spare bit

  assign wait_d     = wr_wait ? req.wdata[`WAIT_MSB:`WAIT_LSB] : wait_q;
  assign wait_rsv_d = wr_wait ? req.wdata[`WAIT_RSV_POS] : wait_rsv_q;

  // Two-cycle reads after reset, changed only while unlocked
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_q     <= `WAIT_RST;
      wait_rsv_q <= `WAIT_RSV_RST;
    end else begin
      wait_q     <= wait_d;
      wait_rsv_q <= wait_rsv_d;
    end
  end

  // ----------------------------------------------------------
  // Flash read sequencer
  // ----------------------------------------------------------

  logic seq_busy;                          // Read in progress
  logic seq_ready;                         // Read data valid pulse
  logic seq_start;                         // New read accepted

  // New read only while idle; the code is sampled at this edge
  assign seq_start = flash_req && !seq_busy;

  // Read takes wait code plus one cycles
  flash_read_seq u_seq (
    .clk       (clk),
    .rst       (rst),
    .start     (seq_start),
    .wait_code (wait_q),
    .busy_q    (seq_busy),
    .ready_q   (seq_ready)
  );

  // ----------------------------------------------------------
  // Status: unlocked level and sticky discarded-write flag
  // ----------------------------------------------------------

  logic drop_q;                            // A protected write was lost
  logic drop_d;                            // Next flag
  logic drop_clr;                          // Software clear

  assign drop_clr = wr_stat && req.wdata[`STAT_DROP_POS];
  // Set beats clear in the same cycle
  assign drop_d   = wr_wait_drop | (drop_q & !drop_clr);

  // Sticky flag
  always_ff @(posedge clk) begin
    if (rst) begin
      drop_q <= 1'b0;
    end else begin
      drop_q <= drop_d;
    end
  end

  // ----------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------

  logic [15:0] cache_word;                 // Cache control as read
  logic [15:0] wait_word;                  // Read-wait as read
  logic [15:0] stat_word;                  // Status as read
  logic [15:0] rdata_d;                    // Selected word

  // Upper bits fixed, bit 1 reads one
  assign cache_word = {`CACHE_RO_VAL, cache_en_q};
  assign wait_word  = {7'h00, wait_rsv_q, 6'h00, wait_q};
  assign stat_word  = {14'h0000, drop_q, lock_open};

  // Unmapped and idle cycles read zero
  assign rdata_d = !req.rd   ? 16'h0000   :
                   hit_lock  ? key_q      :
                   hit_cache ? cache_word :
                   hit_wait  ? wait_word  :
                   hit_stat  ? stat_word  :
                               16'h0000;

  // ----------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_d;
    end
  end

  // Mirrors of internal flops
  always_ff @(posedge clk) begin
    if (rst) begin
      cache_enable    <= `CACHE_EN_RST;
      flash_wait_code <= `WAIT_RST;
      sys_unlocked    <= 1'b0;
    end else begin
      cache_enable    <= cache_en_d;
      flash_wait_code <= wait_d;
      sys_unlocked    <= (wr_lock ? (req.wdata == `UNLOCK_KEY) : lock_open);
    end
  end

  // Sequencer outputs are flops already
  assign flash_busy  = seq_busy;
  assign flash_ready = seq_ready;
  assign cache_flush = cache_flush_q;

endmodule

//--- design/sysctl_consts.svh
`ifndef SYSCTL_CONSTS_SVH
`define SYSCTL_CONSTS_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses on the plain port)
// ------------------------------------------------------------
`define OFS_LOCK        4'h0
`define OFS_CACHE       4'h4
`define OFS_WAIT        4'h8
`define OFS_STAT        4'hC

// ------------------------------------------------------------
// Write-lock key register
// ------------------------------------------------------------
`define UNLOCK_KEY      16'h0096
`define LOCK_RST        16'h0000

// ------------------------------------------------------------
// Cache control register fields
// ------------------------------------------------------------
`define CACHE_EN_POS    0
`define CACHE_EN_RST    1'h0
`define CACHE_RO_VAL    15'h0001

// ------------------------------------------------------------
// Flash read-wait register fields
// ------------------------------------------------------------
`define WAIT_LSB        0
`define WAIT_MSB        1
`define WAIT_RST        2'h1
`define WAIT_RSV_POS    8
`define WAIT_RSV_RST    1'h0

// ------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------
`define STAT_OPEN_POS   0
`define STAT_DROP_POS   1

`endif

//--- design/sysctl_pkg.sv
package sysctl_pkg;

  // Register port request, one cycle
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  // Flash read sequencer states
  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_BUSY = 2'b10
  } rd_state_t;

endpackage

//--- design/write_lock_key.sv
`timescale 1ns/1ps
`include "sysctl_consts.svh"

// Holds the key word and whether protection is lifted
module write_lock_key (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Key write
  input  wire logic        key_wr,
  input  wire logic [15:0] key_data,
  // State
  output logic      [15:0] key_q,
  output logic             open_q
);

  logic open_d;                            // Unlocked after this write

  // Only the exact key lifts protection
  assign open_d = key_wr ? (key_data == `UNLOCK_KEY) : open_q;

  // Key and open flag, closed after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q  <= `LOCK_RST;
      open_q <= 1'b0;
    end else begin
      if (key_wr) begin
        key_q <= key_data;
      end
      open_q <= open_d;
    end
  end

endmodule

//--- sim/sys_protect_chk.sv
`timescale 1ns/1ps
`include "sysctl_consts.svh"

// ----------------------------------------
// Port checks for the protect/cache/wait group
// ----------------------------------------
module sys_protect_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rdata,
  // Cache and flash
  input wire logic        cache_enable,
  input wire logic        cache_flush,
  input wire logic        flash_req,
  input wire logic        flash_busy,
  input wire logic        flash_ready,
  input wire logic [1:0]  flash_wait_code,
  input wire logic        sys_unlocked
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Decoded accesses
  wire       wr_key   = wr_stb && addr == `OFS_LOCK;
  wire       wr_wait  = wr_stb && addr == `OFS_WAIT;
  wire       wr_cache = wr_stb && addr == `OFS_CACHE;
  wire       take_fl  = flash_req && !flash_busy;
  wire [1:0] wd_code  = wdata[1:0];
  wire       wd_en    = wdata[0];

  property p_open; wr_key && wdata == `UNLOCK_KEY |=> sys_unlocked; endproperty
  a_open: assert property (p_open) else $error("key did not unlock");
  property p_close; wr_key && wdata != `UNLOCK_KEY |=> !sys_unlocked; endproperty
  a_close: assert property (p_close) else $error("wrong key left unlocked");
  property p_hold; sys_unlocked && !wr_key |=> sys_unlocked; endproperty
  a_hold: assert property (p_hold) else $error("unlock dropped by itself");
  property p_wlock; !sys_unlocked && wr_wait |=> $stable(flash_wait_code); endproperty
  a_wlock: assert property (p_wlock) else $error("locked wait write took");
  property p_wopen; sys_unlocked && wr_wait |=> flash_wait_code == $past(wd_code); endproperty
  a_wopen: assert property (p_wopen) else $error("open wait write lost");
  property p_cen; wr_cache |=> cache_enable == $past(wd_en) ##1 1'b1; endproperty
  a_cen: assert property (p_cen) else $error("cache enable wrong");
  property p_flush; wr_cache && !wd_en |-> ##[1:2] cache_flush; endproperty
  a_flush: assert property (p_flush) else $error("no flush pulse");
  property p_ro; rd_stb && addr == `OFS_CACHE |=> rdata[15:1] == 15'h0001; endproperty
  a_ro: assert property (p_ro) else $error("cache upper bits wrong");
  property p_fl0; take_fl && flash_wait_code == 2'h0 |=> flash_busy && !flash_ready ##1 flash_ready && !flash_busy;
  endproperty
  a_fl0: assert property (p_fl0) else $error("one-cycle read wrong");
  property p_fl3; take_fl && flash_wait_code == 2'h3 |=> flash_busy [*4] ##1 flash_ready && !flash_busy; endproperty
  a_fl3: assert property (p_fl3) else $error("four-cycle read wrong");

  // Main scenarios reached
  c_relock: cover property (sys_unlocked ##1 !sys_unlocked);
  c_flush: cover property (cache_flush);
  c_long: cover property (flash_busy [*3] ##1 flash_ready);
endmodule

//--- sim/tb_top.sv
`timescale 1ns/1ps
`include "sysctl_consts.svh"

// ----------------------------------------
// Directed register and flash-timing bench
// ----------------------------------------
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic        flash_req = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic        cache_enable, cache_flush, flash_busy, flash_ready, sys_unlocked;
  logic [1:0]  flash_wait_code;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          k;

  sys_protect_cache_flash_wait sys_protect_cache_flash_wait_inst (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .cache_enable(cache_enable), .cache_flush(cache_flush), .flash_req(flash_req),
    .flash_busy(flash_busy), .flash_ready(flash_ready), .flash_wait_code(flash_wait_code),
    .sys_unlocked(sys_unlocked));

  // 100 MHz clock
  initial forever #5 clk = ~clk;

  // Compare one value
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One-cycle write, outputs settled on return
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr   <= a;
    wdata  <= d;
    @(posedge clk);
    wr_stb <= 1'b0;
    #1;
  endtask

  // One-cycle read, data checked in the cycle after
  task rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr   <= a;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // Flash read, busy cycles counted up to the ready pulse
  task fl(input logic [1:0] c);
    int n;
    int t;
    n = 0;
    t = 0;
    @(posedge clk);
    flash_req <= 1'b1;
    @(posedge clk);
    flash_req <= 1'b0;
    #1;
    while (!flash_ready && t < 8) begin
      if (flash_busy) n++;
      t++;
      @(posedge clk);
      #1;
    end
    chk({15'h0000, flash_ready}, 16'h0001);
    chk(16'(n), 16'(c) + 16'h0001);
  endtask

  // Report and stop
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    end_sim;
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rd(`OFS_LOCK, 16'h0000);
    rd(`OFS_CACHE, 16'h0002);
    rd(`OFS_WAIT, 16'h0001);
    wr(`OFS_WAIT, 16'h0003);
    rd(`OFS_WAIT, 16'h0001);
    rd(`OFS_STAT, 16'h0002);
    wr(`OFS_STAT, 16'h0002);
    rd(`OFS_STAT, 16'h0000);
    wr(`OFS_LOCK, `UNLOCK_KEY);
    chk({15'h0000, sys_unlocked}, 16'h0001);
    // Every wait code, then a timed read
    for (int c = 0; c < 4; c++) begin
      wr(`OFS_WAIT, 16'(c));
      chk({14'h0000, flash_wait_code}, 16'(c));
      fl(2'(c));
    end
    // Lower 2 to 1, then three idle cycles before the next read
    wr(`OFS_WAIT, 16'h0002);
    wr(`OFS_WAIT, 16'h0001);
    repeat (2) @(posedge clk);
    fl(2'h1);
    wr(`OFS_WAIT, 16'hFFFF);
    rd(`OFS_WAIT, 16'h0103);
    wr(`OFS_LOCK, 16'h0095);
    rd(`OFS_LOCK, 16'h0095);
    wr(`OFS_WAIT, 16'h0000);
    rd(`OFS_WAIT, 16'h0103);
    wr(`OFS_CACHE, 16'h0001);
    rd(`OFS_CACHE, 16'h0003);
    wr(`OFS_CACHE, 16'h0000);
    k = 0;
    while (!cache_flush && k < 2) begin
      @(posedge clk);
      #1 k++;
    end
    chk({15'h0000, cache_flush}, 16'h0001);
    chk({15'h0000, cache_enable}, 16'h0000);
    rd(4'h2, 16'h0000);
    // Reset in mid-run while unlocked
    wr(`OFS_LOCK, `UNLOCK_KEY);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1 chk({13'h0000, sys_unlocked, flash_wait_code}, 16'h0001);
    rd(`OFS_LOCK, 16'h0000);
    end_sim;
  end
endmodule

bind sys_protect_cache_flash_wait sys_protect_chk sys_protect_chk_inst (
  .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
  .rdata(rdata), .cache_enable(cache_enable), .cache_flush(cache_flush), .flash_req(flash_req),
  .flash_busy(flash_busy), .flash_ready(flash_ready), .flash_wait_code(flash_wait_code),
  .sys_unlocked(sys_unlocked));
